// file: lxb_map.svh
// Constants of the fixed-point and branch execution unit.
// Assumes 32-bit instructions with bit 31 as the most significant bit.
`ifndef LXB_MAP_SVH
`define LXB_MAP_SVH

// Instruction encodings and the masks that select their fixed fields.
`define LXB_OP_ADDZE 32'h7C000194
`define LXB_OP_AND 32'h7C000038
`define LXB_OP_ANDC 32'h7C000078
`define LXB_OP_ANDI 32'h70000000
`define LXB_OP_ANDIS 32'h74000000
`define LXB_OP_UBR 32'h48000000
`define LXB_OP_CBR 32'h40000000
`define LXB_MASK_XO 32'hFC0001FE
`define LXB_MASK_X 32'hFC0007FE
`define LXB_MASK_D 32'hFC000000

// Instruction field positions.
`define LXB_RT_HI 25
`define LXB_RT_LO 21
`define LXB_RA_HI 20
`define LXB_RA_LO 16
`define LXB_OE_BIT 10
`define LXB_REC_BIT 0
`define LXB_ABS_BIT 1
`define LXB_LINK_BIT 0
`define LXB_BOPT0_BIT 25
`define LXB_BOPT1_BIT 24
`define LXB_BOPT2_BIT 23
`define LXB_BOPT3_BIT 22
`define LXB_BOPT4_BIT 21
`define LXB_LDISP_HI 25
`define LXB_LDISP_LO 2
`define LXB_CDISP_HI 15
`define LXB_CDISP_LO 2
`define LXB_IMM_HI 15
`define LXB_IMM_LO 0

// Bit positions in the fixed exception register and condition register.
`define LXB_FX_SUMOVF 31
`define LXB_FX_EXCESS 30
`define LXB_FX_CARRY 29
`define LXB_FX_WMASK 32'hE0000000
`define LXB_CF0_HI 31
`define LXB_CF0_LO 28

// Register offsets on the APB slave.
`define LXB_A_COND 8'h00
`define LXB_A_FX 8'h04
`define LXB_A_RET 8'h08
`define LXB_A_LOOP 8'h0C
`define LXB_A_STAT 8'h10

// Reset values and the instruction step.
`define LXB_RST_WORD 32'h00000000
`define LXB_INSTR_STEP 32'h00000004

`endif

// file: lxb_pkg.sv
// Types of the fixed-point and branch execution unit.
// Assumes the constants header is compiled alongside.
package lxb_pkg;

  typedef enum logic [2:0] {
    LXB_NONE = 3'b000,
    LXB_ADDZE = 3'b001,
    LXB_AND = 3'b010,
    LXB_ANDC = 3'b011,
    LXB_ANDI = 3'b100,
    LXB_ANDIS = 3'b101,
    LXB_UBR = 3'b110,
    LXB_CBR = 3'b111
  } lxb_op_t;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] current_instr_addr;
    logic [31:0] src_a;
    logic [31:0] src_b;
  } lxb_issue_t;

  typedef struct packed {
    logic valid;
    logic [4:0] idx;
    logic [31:0] data;
  } lxb_wb_t;

  typedef struct packed {
    logic valid;
    logic taken;
    logic hint;
    logic [31:0] target;
  } lxb_br_t;

  typedef struct packed {
    logic [31:0] cond_reg;
    logic [31:0] fx_exc;
    logic [31:0] ret_addr;
    logic [31:0] loop_cnt;
    lxb_wb_t wb;
    lxb_br_t br;
    logic illegal;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lxb_state_t;

endpackage : lxb_pkg

// file: lxb_exec.sv
// Execution unit for add-to-zero-extended, the AND family and the two
// immediate branch forms, holding the condition, fixed exception, return
// address and loop counter registers, which software reaches over APB.
// Assumes the fetch stage presents one instruction per cycle with its
// operands read from the general register file, all on CLK_SYS.
//
// Summary of operation
// - Add-zero-extended writes first source plus carry bit to destination.
// - Add-zero-extended always updates carry; overflow bits only when enabled.
// - Add-zero-extended, and, and-complement update field zero only if recorded.
// - Field zero flags come from the 32-bit result, the truncated sum for add-zero-extended.
// - Register and writes source AND second source to target.
// - And-complement writes source AND inverted second source to target.
// - And-immediate uses zero-extended immediate and always updates field zero.
// - And-immediate-shifted uses immediate in upper half, always updates flags.
// - Absolute unconditional branch target is sign-extended long displacement.
// - Relative unconditional branch adds displacement to current address.
// - With link enabled, return address becomes current address plus four.
// - Conditional branch decrements loop counter when option bit two clear.
// - Counter test passes on option bit two or nonzero differing bit three.
// - Condition test passes on option bit zero or matching bit one.
// - Condition select index picks the tested condition register bit.
// - Conditional target is sign-extended displacement, relative or absolute.
// - Ignored option bits have no effect; bits zero and two branch always.
// - Prediction hint is reported but never changes the branch outcome.
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "lxb_map.svh"

module lxb_exec (
  // Clock and reset.
  input wire logic CLK_SYS,
  input wire logic RST,
  // Instruction issue from the fetch stage.
  input wire lxb_pkg::lxb_issue_t ISSUE,
  // Results towards the register file and fetch stage.
  output lxb_pkg::lxb_wb_t WB,
  output lxb_pkg::lxb_br_t BR,
  output logic ILLEGAL,
  // APB slave.
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);

  lxb_pkg::lxb_state_t st_q;
  lxb_pkg::lxb_state_t st_d;
  lxb_pkg::lxb_op_t op;
  logic [32:0] sum;
  logic [31:0] res;
  logic [31:0] cnt_dec;
  logic excess;
  logic sum_ovf;
  logic cnt_ok;
  logic cond_ok;
  logic cond_bit;
  logic apb_acc;
  logic apb_wr;
  logic apb_hit;
  logic [31:0] apb_rd;

  // Field zero flags from a signed comparison with zero.
  function automatic logic [3:0] cf0_flags(input logic [31:0] r,
                                           input logic so);
    cf0_flags = {r[31], ~r[31] & (r != 32'h00000000),
                 r == 32'h00000000, so};
  endfunction : cf0_flags

  // Branch destination, relative to the current address or absolute.
  function automatic logic [31:0] branch_dest(input logic [31:0] current_instr_addr,
                                              input logic [31:0] disp,
                                              input logic abs_sel);
    branch_dest = abs_sel ? disp : current_instr_addr + disp;
  endfunction : branch_dest

  // Opcode decode over the fixed fields of each form.
  function automatic lxb_pkg::lxb_op_t decode_op(input logic [31:0] i);
    decode_op = lxb_pkg::LXB_NONE;
    if ((i & `LXB_MASK_XO) == `LXB_OP_ADDZE)
      decode_op = lxb_pkg::LXB_ADDZE;
    else if ((i & `LXB_MASK_X) == `LXB_OP_AND)
      decode_op = lxb_pkg::LXB_AND;
    else if ((i & `LXB_MASK_X) == `LXB_OP_ANDC)
      decode_op = lxb_pkg::LXB_ANDC;
    else if ((i & `LXB_MASK_D) == `LXB_OP_ANDI)
      decode_op = lxb_pkg::LXB_ANDI;
    else if ((i & `LXB_MASK_D) == `LXB_OP_ANDIS)
      decode_op = lxb_pkg::LXB_ANDIS;
    else if ((i & `LXB_MASK_D) == `LXB_OP_UBR)
      decode_op = lxb_pkg::LXB_UBR;
    else if ((i & `LXB_MASK_D) == `LXB_OP_CBR)
      decode_op = lxb_pkg::LXB_CBR;
  endfunction : decode_op

  assign op = decode_op(ISSUE.instr);
  assign apb_acc = PSEL & PENABLE;
  assign apb_wr = apb_acc & st_q.pready & PWRITE;

  // Register read decode.
  always_comb
  begin
    apb_hit = 1'b1;
    apb_rd = `LXB_RST_WORD;
    unique case (PADDR)
      `LXB_A_COND: apb_rd = st_q.cond_reg;
      `LXB_A_FX: apb_rd = st_q.fx_exc;
      `LXB_A_RET: apb_rd = st_q.ret_addr;
      `LXB_A_LOOP: apb_rd = st_q.loop_cnt;
      `LXB_A_STAT: apb_rd = {29'h00000000, st_q.illegal, st_q.br.taken,
                             st_q.br.hint};
      default: apb_hit = 1'b0;
    endcase
  end

  always_comb
  begin
    st_d = st_q;
    st_d.wb.valid = 1'b0;
    st_d.br.valid = 1'b0;
    st_d.illegal = 1'b0;
    // Bus: setup, one wait cycle, then the ready access edge.
    st_d.pready = apb_acc & ~st_q.pready;
    if (apb_acc & ~st_q.pready)
    begin
      st_d.prdata = apb_rd;
      st_d.pslverr = ~apb_hit;
    end
    if (apb_wr & apb_hit)
    begin
      unique case (PADDR)
        `LXB_A_COND: st_d.cond_reg = PWDATA;
        `LXB_A_FX: st_d.fx_exc = PWDATA & `LXB_FX_WMASK;
        `LXB_A_RET: st_d.ret_addr = PWDATA;
        `LXB_A_LOOP: st_d.loop_cnt = PWDATA;
        default: st_d.illegal = 1'b0;
      endcase
    end
    sum = {1'b0, ISSUE.src_a} + {32'h00000000, st_q.fx_exc[`LXB_FX_CARRY]};
    excess = ~ISSUE.src_a[31] & sum[31];
    res = `LXB_RST_WORD;
    cnt_dec = st_q.loop_cnt - 32'h00000001;
    cnt_ok = 1'b0;
    cond_ok = 1'b0;
    cond_bit = st_q.cond_reg[5'h1F - ISSUE.instr[`LXB_RA_HI:`LXB_RA_LO]];
    sum_ovf = st_d.fx_exc[`LXB_FX_SUMOVF];
    // Execution overrides a same-cycle bus write to the same register.
    if (ISSUE.valid)
    begin
      unique case (op)
        lxb_pkg::LXB_NONE:
          st_d.illegal = 1'b1;
        lxb_pkg::LXB_ADDZE:
        begin
          res = sum[31:0];
          st_d.fx_exc[`LXB_FX_CARRY] = sum[32];
          if (ISSUE.instr[`LXB_OE_BIT])
          begin
            st_d.fx_exc[`LXB_FX_EXCESS] = excess;
            st_d.fx_exc[`LXB_FX_SUMOVF] = st_q.fx_exc[`LXB_FX_SUMOVF] | excess;
          end
          sum_ovf = st_d.fx_exc[`LXB_FX_SUMOVF];
        end
        lxb_pkg::LXB_AND:
          res = ISSUE.src_a & ISSUE.src_b;
        lxb_pkg::LXB_ANDC:
          res = ISSUE.src_a & ~ISSUE.src_b;
        lxb_pkg::LXB_ANDI:
          res = ISSUE.src_a &
                {16'h0000, ISSUE.instr[`LXB_IMM_HI:`LXB_IMM_LO]};
        lxb_pkg::LXB_ANDIS:
          res = ISSUE.src_a &
                {ISSUE.instr[`LXB_IMM_HI:`LXB_IMM_LO], 16'h0000};
        lxb_pkg::LXB_UBR:
        begin
          st_d.br.valid = 1'b1;
          st_d.br.taken = 1'b1;
          st_d.br.hint = 1'b0;
          st_d.br.target = branch_dest(ISSUE.current_instr_addr,
            {{6{ISSUE.instr[`LXB_LDISP_HI]}},
             ISSUE.instr[`LXB_LDISP_HI:`LXB_LDISP_LO], 2'b00},
            ISSUE.instr[`LXB_ABS_BIT]);
        end
        lxb_pkg::LXB_CBR:
        begin
          if (!ISSUE.instr[`LXB_BOPT2_BIT])
            st_d.loop_cnt = cnt_dec;
          cnt_ok = ISSUE.instr[`LXB_BOPT2_BIT] |
                   ((cnt_dec != 32'h00000000) ^ ISSUE.instr[`LXB_BOPT3_BIT]);
          cond_ok = ISSUE.instr[`LXB_BOPT0_BIT] |
                    (cond_bit == ISSUE.instr[`LXB_BOPT1_BIT]);
          st_d.br.valid = 1'b1;
          st_d.br.taken = cnt_ok & cond_ok;
          st_d.br.hint = ISSUE.instr[`LXB_BOPT4_BIT];
          st_d.br.target = (cnt_ok & cond_ok) ?
            branch_dest(ISSUE.current_instr_addr,
              {{16{ISSUE.instr[`LXB_CDISP_HI]}},
               ISSUE.instr[`LXB_CDISP_HI:`LXB_CDISP_LO], 2'b00},
              ISSUE.instr[`LXB_ABS_BIT]) :
            ISSUE.current_instr_addr + `LXB_INSTR_STEP;
        end
      endcase
      if ((op == lxb_pkg::LXB_UBR || op == lxb_pkg::LXB_CBR) &&
          ISSUE.instr[`LXB_LINK_BIT])
        st_d.ret_addr = ISSUE.current_instr_addr + `LXB_INSTR_STEP;
      if (op != lxb_pkg::LXB_NONE && op != lxb_pkg::LXB_UBR &&
          op != lxb_pkg::LXB_CBR)
      begin
        st_d.wb.valid = 1'b1;
        st_d.wb.data = res;
        st_d.wb.idx = (op == lxb_pkg::LXB_ADDZE) ?
                      ISSUE.instr[`LXB_RT_HI:`LXB_RT_LO] :
                      ISSUE.instr[`LXB_RA_HI:`LXB_RA_LO];
        if (op == lxb_pkg::LXB_ANDI || op == lxb_pkg::LXB_ANDIS ||
            ISSUE.instr[`LXB_REC_BIT])
          st_d.cond_reg[`LXB_CF0_HI:`LXB_CF0_LO] = cf0_flags(res, sum_ovf);
      end
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign WB = st_q.wb;
  assign BR = st_q.br;
  assign ILLEGAL = st_q.illegal;
  assign PRDATA = st_q.prdata;
  assign PREADY = st_q.pready;
  assign PSLVERR = st_q.pslverr;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  AST_ADDZE_SUM: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ADDZE |=> WB.valid &&
    WB.data == $past(ISSUE.src_a) +
               {31'h00000000, $past(st_q.fx_exc[`LXB_FX_CARRY])})
    else $error("Add zero-extended result wrong.");

  AST_ADDZE_OE: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ADDZE && !ISSUE.instr[`LXB_OE_BIT]
    && !apb_wr |=> st_q.fx_exc[31:30] == $past(st_q.fx_exc[31:30]))
    else $error("Overflow bits changed without enable.");

  AST_REC_GATE: assert property (
    ISSUE.valid && !ISSUE.instr[`LXB_REC_BIT] && !apb_wr &&
    (op == lxb_pkg::LXB_AND || op == lxb_pkg::LXB_ANDC) |=>
    $stable(st_q.cond_reg))
    else $error("Condition field changed without record.");

  AST_ANDI_FLAGS: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ANDI |=>
    $onehot(st_q.cond_reg[31:29]) &&
    st_q.cond_reg[29] == (WB.data == 32'h00000000))
    else $error("Immediate AND flags wrong.");

  AST_ANDC: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ANDC |=>
    WB.data == ($past(ISSUE.src_a) & ~$past(ISSUE.src_b)))
    else $error("AND with complement result wrong.");

  AST_CNT_DEC: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_CBR && !ISSUE.instr[`LXB_BOPT2_BIT]
    && !apb_wr |=> st_q.loop_cnt == $past(st_q.loop_cnt) - 32'h00000001)
    else $error("Loop counter not decremented.");

  AST_CBR_ALWAYS: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_CBR && ISSUE.instr[`LXB_BOPT0_BIT] &&
    ISSUE.instr[`LXB_BOPT2_BIT] |=> BR.valid && BR.taken)
    else $error("Unconditional option did not branch.");

  AST_LINK: assert property (
    ISSUE.valid && ISSUE.instr[`LXB_LINK_BIT] &&
    (op == lxb_pkg::LXB_UBR || op == lxb_pkg::LXB_CBR) |=>
    st_q.ret_addr == $past(ISSUE.current_instr_addr) + `LXB_INSTR_STEP)
    else $error("Return address not updated.");

  AST_UNTOUCHED: assert property (
    ISSUE.valid && !apb_wr && op != lxb_pkg::LXB_NONE &&
    op != lxb_pkg::LXB_ADDZE && op != lxb_pkg::LXB_CBR |=>
    $stable(st_q.loop_cnt) && $stable(st_q.fx_exc))
    else $error("Counter or exception register altered.");

  AST_AND_REG: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_AND |=>
    WB.valid && WB.data == ($past(ISSUE.src_a) & $past(ISSUE.src_b)))
    else $error("Register AND result wrong.");

  AST_ANDIS: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ANDIS |=>
    WB.data == ($past(ISSUE.src_a) &
                {$past(ISSUE.instr[`LXB_IMM_HI:`LXB_IMM_LO]), 16'h0000}) &&
    $onehot(st_q.cond_reg[31:29]))
    else $error("Shifted immediate AND wrong.");

  AST_UBR_TARGET: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_UBR |=>
    BR.valid && BR.taken && BR.target ==
    ($past(ISSUE.instr[`LXB_ABS_BIT]) ? 32'h00000000 : $past(ISSUE.current_instr_addr)) +
    {{6{$past(ISSUE.instr[`LXB_LDISP_HI])}},
     $past(ISSUE.instr[`LXB_LDISP_HI:`LXB_LDISP_LO]), 2'b00})
    else $error("Unconditional branch target wrong.");

  AST_CBR_TAKEN: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_CBR |=>
    BR.valid && BR.taken ==
    (($past(ISSUE.instr[`LXB_BOPT2_BIT]) ||
      (($past(st_q.loop_cnt) != 32'h00000001) !=
       $past(ISSUE.instr[`LXB_BOPT3_BIT]))) &&
     ($past(ISSUE.instr[`LXB_BOPT0_BIT]) ||
      $past(st_q.cond_reg[5'h1F - ISSUE.instr[`LXB_RA_HI:`LXB_RA_LO]]) ==
      $past(ISSUE.instr[`LXB_BOPT1_BIT]))))
    else $error("Conditional branch outcome wrong.");

  AST_CBR_TARGET: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_CBR |=>
    BR.target == (!BR.taken ? $past(ISSUE.current_instr_addr) + `LXB_INSTR_STEP :
    ($past(ISSUE.instr[`LXB_ABS_BIT]) ? 32'h00000000 : $past(ISSUE.current_instr_addr)) +
    {{16{$past(ISSUE.instr[`LXB_CDISP_HI])}},
     $past(ISSUE.instr[`LXB_CDISP_HI:`LXB_CDISP_LO]), 2'b00}))
    else $error("Conditional branch target wrong.");

  AST_HINT: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_CBR |=>
    BR.hint == $past(ISSUE.instr[`LXB_BOPT4_BIT]))
    else $error("Branch hint not reported.");

  AST_CF0_SO: assert property (
    ISSUE.valid && (op == lxb_pkg::LXB_ANDI || op == lxb_pkg::LXB_ANDIS ||
    (ISSUE.instr[`LXB_REC_BIT] && (op == lxb_pkg::LXB_ADDZE ||
    op == lxb_pkg::LXB_AND || op == lxb_pkg::LXB_ANDC))) |=>
    $onehot(st_q.cond_reg[31:29]) &&
    st_q.cond_reg[`LXB_CF0_LO] == st_q.fx_exc[`LXB_FX_SUMOVF])
    else $error("Field zero summary bit wrong.");

  AST_ADDZE_CARRY: assert property (
    ISSUE.valid && op == lxb_pkg::LXB_ADDZE |=>
    st_q.fx_exc[`LXB_FX_CARRY] == ($past(ISSUE.src_a) == 32'hFFFFFFFF &&
    $past(st_q.fx_exc[`LXB_FX_CARRY])))
    else $error("Carry bit wrong.");

endmodule : lxb_exec

// file: lxb_gpr_model.sv
// General register file model that feeds operands to the execution unit.
// Assumes results are written back at the edge after their pulse.
`timescale 1ns/1ps
module lxb_gpr_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Operand selection and writeback.
  input wire logic [31:0] instr,
  input wire lxb_pkg::lxb_wb_t wb,
  output logic [31:0] src_a,
  output logic [31:0] src_b
);
  logic [31:0] gpr [32];
  logic is_add;
  assign is_add = instr[9:1] == 9'h0CA;
  assign src_a = is_add ? gpr[instr[20:16]] : gpr[instr[25:21]];
  assign src_b = gpr[instr[15:11]];
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (rst)
        gpr[i] <= 32'hFFFFFFFF >> i;
      else if (wb.valid && wb.idx == i[4:0])
        gpr[i] <= wb.data;
    end
  end
endmodule : lxb_gpr_model

// file: tb_logic_add_branch_exec.sv
// Self-checking bench for the execution unit.
// Assumes the register file model supplies the operands.
`timescale 1ns/1ps
`include "lxb_map.svh"
module tb_logic_add_branch_exec;
  typedef struct packed {
    logic [31:0] ins;
    logic [31:0] fx_in;
    logic [4:0] idx;
    logic [31:0] data;
    logic [3:0] cf;
    logic [31:0] fx;
  } lxb_drow_t;
  typedef struct packed {
    logic [4:0] bo;
    logic [4:0] bi;
    logic aa;
    logic [31:0] ctr;
    logic tk;
    logic [31:0] ctr_e;
  } lxb_crow_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic iv = 1'b0;
  logic [31:0] ins = 32'h00000000;
  logic [31:0] current_instr_addr = 32'h00000000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] src_a, src_b, prdata, rd;
  logic pready, pslverr, er, illegal;
  lxb_pkg::lxb_wb_t wb;
  lxb_pkg::lxb_br_t br;
  int fails = 0;
  int cmp_count = 0;
  lxb_drow_t drows [10] = '{
    '{32'h7E800595, 32'h20000000, 5'h14, 32'h00000000, 4'h2, 32'h20000000},
    '{32'h7EA10595, 32'h20000000, 5'h15, 32'h80000000, 4'h9, 32'hC0000000},
    '{32'h7EC10194, 32'h20000000, 5'h16, 32'h80000000, 4'h0, 32'h00000000},
    '{32'h7EE20195, 32'h80000000, 5'h17, 32'h3FFFFFFF, 4'h5, 32'h80000000},
    '{32'h7C181839, 32'h00000000, 5'h18, 32'h1FFFFFFF, 4'h4, 32'h00000000},
    '{32'h7C190879, 32'h00000000, 5'h19, 32'h80000000, 4'h8, 32'h00000000},
    '{32'h7C9A0038, 32'h20000000, 5'h1A, 32'h0FFFFFFF, 4'h0, 32'h20000000},
    '{32'h701B8001, 32'hA0000000, 5'h1B, 32'h00008001, 4'h5, 32'hA0000000},
    '{32'h743C8001, 32'h00000000, 5'h1C, 32'h00010000, 4'h4, 32'h00000000},
    '{32'h73FDFFFE, 32'h00000000, 5'h1D, 32'h00000000, 4'h2, 32'h00000000}
  };
  // ignored option bits clear except in the second row.
  lxb_crow_t crows [13] = '{
    '{5'h14, 5'h00, 1'b1, 32'h7, 1'b1, 32'h7},
    '{5'h1F, 5'h01, 1'b0, 32'h7, 1'b1, 32'h7},
    '{5'h10, 5'h01, 1'b0, 32'h2, 1'b1, 32'h1},
    '{5'h10, 5'h01, 1'b0, 32'h1, 1'b0, 32'h0},
    '{5'h12, 5'h01, 1'b1, 32'h1, 1'b1, 32'h0},
    '{5'h0C, 5'h00, 1'b0, 32'h9, 1'b1, 32'h9},
    '{5'h0C, 5'h01, 1'b0, 32'h9, 1'b0, 32'h9},
    '{5'h04, 5'h01, 1'b1, 32'h9, 1'b1, 32'h9},
    '{5'h08, 5'h00, 1'b0, 32'h3, 1'b1, 32'h2},
    '{5'h00, 5'h01, 1'b0, 32'h0, 1'b1, 32'hFFFFFFFF},
    '{5'h0D, 5'h01, 1'b0, 32'h9, 1'b0, 32'h9},
    '{5'h0C, 5'h1F, 1'b0, 32'h9, 1'b1, 32'h9},
    '{5'h0A, 5'h00, 1'b0, 32'h1, 1'b1, 32'h0}
  };
  always #5 clk = ~clk;
  lxb_exec lxb_exec_inst (
    .CLK_SYS(clk),
    .RST(rst),
    .ISSUE({iv, ins, current_instr_addr, src_a, src_b}),
    .WB(wb),
    .BR(br),
    .ILLEGAL(illegal),
    .PSEL(psel),
    .PENABLE(penable),
    .PWRITE(pwrite),
    .PADDR(paddr),
    .PWDATA(pwdata),
    .PRDATA(prdata),
    .PREADY(pready),
    .PSLVERR(pslverr)
  );
  lxb_gpr_model lxb_gpr_model_inst (
    .clk(clk),
    .rst(rst),
    .instr(ins),
    .wb(wb),
    .src_a(src_a),
    .src_b(src_b)
  );
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic exec(input logic [31:0] i, input logic [31:0] c);
    @(posedge clk);
    ins <= i;
    current_instr_addr <= c;
    iv <= 1'b1;
    @(posedge clk);
    iv <= 1'b0;
    #1;
  endtask : exec
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (5000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  initial
  begin
    int k;
    logic [31:0] c, t, r;
    r = 32'h00000000;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 10; k++)
    begin
      apb(1'b1, `LXB_A_FX, drows[k].fx_in, rd, er);
      apb(1'b1, `LXB_A_COND, 32'h00000000, rd, er);
      exec(drows[k].ins, 32'h00001000);
      cmp(wb.valid, 1'b1);
      cmp(wb.idx, drows[k].idx);
      cmp(wb.data, drows[k].data);
      apb(1'b0, `LXB_A_COND, 32'h00000000, rd, er);
      cmp(rd, {drows[k].cf, 28'h0000000});
      apb(1'b0, `LXB_A_FX, 32'h00000000, rd, er);
      cmp(rd, drows[k].fx);
    end
    $display("test data rows done");
    apb(1'b1, `LXB_A_LOOP, 32'h00000005, rd, er);
    apb(1'b1, `LXB_A_FX, 32'hE0000000, rd, er);
    for (k = 0; k < 4; k++)
    begin
      c = 32'h00001000 + 32'(k) * 32'h00000100;
      exec(`LXB_OP_UBR | 32'h03FFFFF0 | 32'(k), c);
      t = k[1] ? 32'hFFFFFFF0 : c + 32'hFFFFFFF0;
      if (k[0])
        r = c + `LXB_INSTR_STEP;
      cmp(br.taken, 1'b1);
      cmp(br.target, t);
      apb(1'b0, `LXB_A_RET, 32'h00000000, rd, er);
      cmp(rd, r);
    end
    apb(1'b0, `LXB_A_LOOP, 32'h00000000, rd, er);
    cmp(rd, 32'h00000005);
    apb(1'b0, `LXB_A_FX, 32'h00000000, rd, er);
    cmp(rd, 32'hE0000000);
    $display("test branch done");
    for (k = 0; k < 13; k++)
    begin
      c = 32'h00002000 + 32'(k) * 32'h00000010;
      apb(1'b1, `LXB_A_COND, 32'h80000001, rd, er);
      apb(1'b1, `LXB_A_LOOP, crows[k].ctr, rd, er);
      exec(`LXB_OP_CBR | {6'h00, crows[k].bo, crows[k].bi, 16'hFFF0}
        | {30'h00000000, crows[k].aa, 1'b1}, c);
      t = crows[k].aa ? 32'hFFFFFFF0 : c + 32'hFFFFFFF0;
      if (!crows[k].tk)
        t = c + `LXB_INSTR_STEP;
      cmp(br.valid, 1'b1);
      cmp(br.taken, crows[k].tk);
      cmp(br.hint, crows[k].bo[0]);
      cmp(br.target, t);
      apb(1'b0, `LXB_A_LOOP, 32'h00000000, rd, er);
      cmp(rd, crows[k].ctr_e);
      apb(1'b0, `LXB_A_RET, 32'h00000000, rd, er);
      cmp(rd, c + `LXB_INSTR_STEP);
    end
    $display("test conditional rows done");
    exec(32'h00000000, 32'h00000000);
    cmp(illegal, 1'b1);
    cmp(wb.valid, 1'b0);
    cmp(br.valid, 1'b0);
    apb(1'b1, `LXB_A_FX, 32'hFFFFFFFF, rd, er);
    apb(1'b0, `LXB_A_FX, 32'h00000000, rd, er);
    cmp(rd, `LXB_FX_WMASK);
    apb(1'b1, 8'h14, 32'h12345678, rd, er);
    cmp(er, 1'b1);
    apb(1'b0, 8'h14, 32'h00000000, rd, er);
    cmp(er, 1'b1);
    cmp(rd, 32'h00000000);
    apb(1'b1, `LXB_A_STAT, 32'hFFFFFFFF, rd, er);
    apb(1'b0, `LXB_A_STAT, 32'h00000000, rd, er);
    cmp(rd, 32'h00000002);
    $display("test refusals done");
    apb(1'b1, `LXB_A_LOOP, 32'h00000005, rd, er);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      apb(1'b0, 8'(4 * k), 32'h00000000, rd, er);
      cmp(rd, `LXB_RST_WORD);
    end
    cmp(br.valid, 1'b0);
    $display("test reset done");
    report_and_stop();
  end
endmodule : tb_logic_add_branch_exec
